// ==== pin_source.sv ====
// Purpose: Far-side pulse source on the channel input pin
// Assumes: Driven from the bench clock
// Notes: Idle level low; one full high-low pulse per request
`timescale 1ns/1ns
`default_nettype none
module pin_source (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic go,
	output logic pin,
	output logic busy
);
	logic [3:0] left; // Cycles left in the pulse
	// Four cycles high then four low, so both edges survive the sync
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			left <= 4'h0;
		end else if (go) begin
			left <= 4'h8;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
		end
	end
	assign pin = (left > 4'h4);
	assign busy = (left != 4'h0);
endmodule : pin_source
`default_nettype wire

// ==== timer_reload_channel.sv ====
// Purpose: One 16-bit reloadable timer channel: timer and event counter modes.
// Assumes: Pins are asynchronous; chaining pulses come from the same clock.
// Notes: Two-phase counting is not built; only its select bits are stored.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Timer mode counts down on chosen source tick.
// - Timer underflow reloads and keeps counting.
// - Timer underflow every n+1 ticks.
// - Count only while run flag is one.
// - Timer underflow raises interrupt request.
// - Gate option lets input pin suspend counting.
// - Timer pulse output toggles on underflow.
// - Stopped write loads reload and counter.
// - Running write loads reload only.
// - Timer register read returns live count.
// - Event mode counts selected input edge.
// - Other timer overflows may be events.
// - Direction by software or output pin.
// - Event wrap reloads unless free-run.
// - Up period FFFF-n+1, down n+1.
// - Event mode interrupts on both wraps.
// - Free-run wraps without reloading.
// - Event pulse output toggles on wraps.
// - Output pin: port, toggle, or direction.
// - Two-phase selects only on channels 2-4.
// - Channels 1 and 2 have no pins.
// - Eight start flags, one byte, reset zero.
// - Up/down flag: 0 down, 1 up.
module timer_reload_channel #(
	parameter int CHAN_INDEX = 0 // Channel number 0..4
) (
	input wire logic clk,
	input wire logic sys_rst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Count sources from neighbouring logic, one-cycle pulses
	input wire logic subclk_div_thirtytwo,
	input wire logic second_group_channel_two,
	input wire logic other_first_group_channel,
	// Pins
	input wire logic timer_input_pin,
	input wire logic timer_output_pin_in,
	output logic timer_output_pin_out,
	output logic timer_output_pin_oe,
	// Events
	output logic irq_request,
	output logic wrap_pulse
);
	// Channels 1 and 2 have no pins at all
	localparam bit HAS_PINS = (CHAN_INDEX != 1) && (CHAN_INDEX != 2);
	localparam bit HAS_TWO_PHASE = CHAN_INDEX >= timer_reload_pkg::TWO_PHASE_FIRST_CHAN;

	// ****************************************
	// Helpers
	// ****************************************
	// Byte-lane merge of a 16-bit field
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction : merge16

	// ****************************************
	// State
	// ****************************************
	logic [15:0] count; // Live counter
	logic [15:0] reload; // Reload register
	logic [7:0] start_flags; // Count-start flags of both groups
	logic [7:0] updown_flags; // Direction and two-phase selects
	timer_reload_pkg::mode_t mode; // Mode fields
	logic [4:0] prescale; // Free-running divider
	logic in_s1, in_s2, in_s3; // Input pin synchroniser and edge history
	logic dir_s1, dir_s2; // Output pin read back as direction input
	logic aw_held, w_held; // Write halves already taken
	logic [7:0] aw_addr; // Latched write address
	logic [31:0] w_data; // Latched write data
	logic [3:0] w_strb; // Latched byte strobes
	logic running; // Start flag of this channel, also shown in status
	logic count_up; // Step direction, also shown in status

	// ****************************************
	// Register bus, write side
	// ****************************************
	logic do_write; // Both halves present, response slot free
	logic wr_timer; // Write hits the timer register
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_timer = do_write && (aw_addr == timer_reload_pkg::ADDR_TIMER);

	// Address and data are taken independently, in either order
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awready && s_axi_awvalid) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end else if (!aw_held && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (do_write) begin
				w_held <= 1'b0;
			end else if (!w_held && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response, error for an unmapped address
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= timer_reload_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr)
				timer_reload_pkg::ADDR_TIMER, timer_reload_pkg::ADDR_START,
				timer_reload_pkg::ADDR_UPDOWN, timer_reload_pkg::ADDR_MODE,
				timer_reload_pkg::ADDR_STATUS: begin
					s_axi_bresp <= timer_reload_pkg::RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= timer_reload_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Mode is eleven bits wide, so the top five merged bits are cut on purpose
	logic [15:0] mode_merged; // Mode word after byte-lane merge
	assign mode_merged = merge16({5'h00, mode}, w_data, w_strb);

	// Control registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_flags <= timer_reload_pkg::START_RESET;
			updown_flags <= timer_reload_pkg::UPDOWN_RESET;
			mode <= timer_reload_pkg::MODE_RESET;
		end else if (do_write) begin
			if (aw_addr == timer_reload_pkg::ADDR_START && w_strb[0]) begin
				start_flags <= w_data[7:0];
			end
			if (aw_addr == timer_reload_pkg::ADDR_UPDOWN && w_strb[0]) begin
				// Two-phase selects only stick where the channel offers them
				updown_flags <= HAS_TWO_PHASE ? w_data[7:0]
					: (w_data[7:0] & ~timer_reload_pkg::TWO_PHASE_MASK);
			end
			if (aw_addr == timer_reload_pkg::ADDR_MODE) begin
				mode <= timer_reload_pkg::mode_t'(mode_merged[10:0]);
			end
		end
	end

	// ****************************************
	// Register bus, read side
	// ****************************************
	logic [31:0] read_word; // Decoded read data
	logic read_hit; // Address is mapped
	always_comb begin
		read_word = 32'h0000_0000;
		read_hit = 1'b1;
		case (s_axi_araddr)
			timer_reload_pkg::ADDR_TIMER: begin
				read_word = {16'h0000, count};
			end
			timer_reload_pkg::ADDR_START: begin
				read_word = {24'h00_0000, start_flags};
			end
			timer_reload_pkg::ADDR_UPDOWN: begin
				read_word = {24'h00_0000, updown_flags};
			end
			timer_reload_pkg::ADDR_MODE: begin
				read_word = {21'h00_0000, mode};
			end
			timer_reload_pkg::ADDR_STATUS: begin
				read_word = {28'h000_0000, in_s2, count_up, timer_output_pin_out, running};
			end
			default: begin
				read_hit = 1'b0;
			end
		endcase
	end

	// One read at a time; address is refused while data waits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= timer_reload_pkg::RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= read_hit ? timer_reload_pkg::RESP_OKAY : timer_reload_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// Pin synchronisers and prescaler
	// ****************************************
	// Pins are asynchronous; the first stage feeds only the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			in_s1 <= 1'b0;
			in_s2 <= 1'b0;
			in_s3 <= 1'b0;
			dir_s1 <= 1'b0;
			dir_s2 <= 1'b0;
		end else begin
			in_s1 <= timer_input_pin;
			in_s2 <= in_s1;
			in_s3 <= in_s2;
			dir_s1 <= timer_output_pin_in;
			dir_s2 <= dir_s1;
		end
	end

	// Divider runs free so the phase does not depend on the start flag
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prescale <= timer_reload_pkg::PRESCALE_RESET;
		end else begin
			prescale <= prescale + 5'h01;
		end
	end

	// ****************************************
	// Count enable and direction
	// ****************************************
	logic src_tick; // Internal count-source tick
	logic gate_open; // Gate pin allows counting
	logic event_tick; // Event-mode count event
	logic count_tick; // Counter steps this cycle
	logic at_wrap; // Counter at its wrap point
	assign running = start_flags[CHAN_INDEX];

	always_comb begin
		case (mode.clk_src)
			timer_reload_pkg::SRC_DIV_ONE: src_tick = 1'b1;
			timer_reload_pkg::SRC_DIV_EIGHT: src_tick = prescale[2:0] == timer_reload_pkg::DIV8_LAST[2:0];
			timer_reload_pkg::SRC_DIV_THIRTYTWO: src_tick = prescale == timer_reload_pkg::DIV32_LAST;
			timer_reload_pkg::SRC_SUBCLK: src_tick = subclk_div_thirtytwo;
			default: src_tick = 1'b0;
		endcase
	end

	// Gate only exists where the channel has an input pin
	assign gate_open = !(HAS_PINS && mode.gate_en) || (in_s2 == mode.gate_high);

	always_comb begin
		case (mode.event_src)
			timer_reload_pkg::EV_PIN: begin
				// Edge taken from the two settled stages only
				event_tick = HAS_PINS && (mode.rising_edge ? (in_s2 && !in_s3)
					: (!in_s2 && in_s3));
			end
			timer_reload_pkg::EV_SECOND_GROUP: event_tick = second_group_channel_two;
			timer_reload_pkg::EV_OTHER_CHAN: event_tick = other_first_group_channel;
			default: event_tick = 1'b0;
		endcase
	end

	assign count_tick = running && (mode.event_mode ? event_tick : (src_tick && gate_open));
	// Timer mode always counts down; event mode takes flag or pin
	assign count_up = mode.event_mode && ((HAS_PINS && mode.dir_from_pin) ? dir_s2
		: updown_flags[CHAN_INDEX]);
	assign at_wrap = count_up ? (count == timer_reload_pkg::COUNT_MAX)
		: (count == timer_reload_pkg::COUNT_MIN);

	// ****************************************
	// Counter and reload register
	// ****************************************
	// Reload always follows a timer write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reload <= timer_reload_pkg::TIMER_RESET;
		end else if (wr_timer) begin
			reload <= merge16(reload, w_data, w_strb);
		end
	end

	// Stopped writes load the counter too; running ones wait for a wrap
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= timer_reload_pkg::TIMER_RESET;
		end else if (wr_timer && !running) begin
			count <= merge16(reload, w_data, w_strb);
		end else if (count_tick) begin
			if (at_wrap && !(mode.event_mode && mode.free_run)) begin
				count <= reload;
			end else if (count_up) begin
				count <= count + 16'h0001;
			end else begin
				count <= count - 16'h0001;
			end
		end
	end

	// ****************************************
	// Wrap events and output pin
	// ****************************************
	logic wrap_now; // Underflow or overflow this cycle
	assign wrap_now = count_tick && at_wrap;

	// One-cycle request per wrap, in both modes
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_request <= 1'b0;
			wrap_pulse <= 1'b0;
		end else begin
			irq_request <= wrap_now;
			wrap_pulse <= wrap_now;
		end
	end

	// Pin drives only as toggle output; otherwise left to the port logic or read as direction
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_output_pin_out <= 1'b0;
			timer_output_pin_oe <= 1'b0;
		end else begin
			timer_output_pin_oe <= HAS_PINS && mode.pulse_out
				&& !(mode.event_mode && mode.dir_from_pin);
			if (HAS_PINS && mode.pulse_out && wrap_now) begin
				timer_output_pin_out <= !timer_output_pin_out;
			end
		end
	end
endmodule : timer_reload_channel

`default_nettype wire

// ==== timer_reload_channel_tb.sv ====
// Purpose: Self-checking bench for the reloadable timer channel
// Assumes: Channel 0, which has both pins
// Notes: Periods measured between interrupt pulses
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED at %0t got %h exp %h", $time, (a), (e)); end end
module timer_reload_channel_tb;
	localparam int LIMIT = 20000; // Run needs under two thousand cycles
	logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d0, d1;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic subclk_div_thirtytwo, second_group_channel_two, other_first_group_channel;
	logic timer_input_pin, timer_output_pin_in, timer_output_pin_out, timer_output_pin_oe;
	logic irq_request, wrap_pulse, go, busy, ext_dir;
	int n_fail = 0, comparisons = 0, cyc = 0, last = 0, period = 0, n_irq = 0;
	int exp_per[4] = '{2, 16, 64, 8}; // Reload 1 under f/1, f/8, f/32, sub-clock
	timer_reload_channel i_dut (.*);
	pin_source i_src (.clk(clk), .sys_rst(sys_rst), .go(go), .pin(timer_input_pin), .busy(busy));
	// Own drive wins on the shared pin, else the far side's level
	assign timer_output_pin_in = timer_output_pin_oe ? timer_output_pin_out : ext_dir;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cycle count, sub-clock every fourth cycle, wrap spacing, timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		subclk_div_thirtytwo <= (cyc[1:0] == 2'h3);
		if (irq_request === 1'b1) begin
			period <= cyc - last;
			last <= cyc;
			n_irq <= n_irq + 1;
		end
		if (cyc == LIMIT) begin
			n_fail++;
			test_done();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// Wait for n more wraps; the period lands in the same update
	task automatic wirq(input int n);
		int k;
		k = n_irq;
		wait (n_irq == k + n);
		#1;
	endtask : wirq
	// One count event: pin pulse via the partner, or a chaining pulse
	task automatic send(input int src);
		@(posedge clk);
		go <= (src == 0);
		second_group_channel_two <= (src == 1);
		other_first_group_channel <= (src == 2);
		@(posedge clk);
		go <= 1'b0;
		second_group_channel_two <= 1'b0;
		other_first_group_channel <= 1'b0;
		// Busy only shows from the edge after go is taken, so look one edge on
		do @(posedge clk); while (busy);
		repeat (4) @(posedge clk);
	endtask : send
	task automatic t_reset();
		rd(timer_reload_pkg::ADDR_START, d0, rsp);
		`CHK(d0[7:0], timer_reload_pkg::START_RESET)
		rd(timer_reload_pkg::ADDR_UPDOWN, d0, rsp);
		`CHK(d0[7:0], timer_reload_pkg::UPDOWN_RESET)
		wr(timer_reload_pkg::ADDR_START, 32'hFF);
		rd(timer_reload_pkg::ADDR_START, d0, rsp);
		`CHK(d0[7:0], 8'hFF)
		wr(timer_reload_pkg::ADDR_START, 32'h0);
		rd(8'h40, d0, rsp);
		`CHK(rsp, timer_reload_pkg::RESP_SLVERR)
		$display("reset test done");
	endtask : t_reset
	task automatic t_timer();
		wr(timer_reload_pkg::ADDR_TIMER, 32'h3);
		rd(timer_reload_pkg::ADDR_TIMER, d0, rsp);
		`CHK(d0[15:0], 16'h0003)
		wr(timer_reload_pkg::ADDR_MODE, 32'h20);
		wr(timer_reload_pkg::ADDR_START, 32'h1);
		wirq(2);
		`CHK(period, 4)
		d1[0] = timer_output_pin_out;
		wirq(1);
		`CHK(timer_output_pin_out, ~d1[0])
		wr(timer_reload_pkg::ADDR_TIMER, 32'h5);
		rd(timer_reload_pkg::ADDR_TIMER, d0, rsp);
		// Counter still runs out the old period of four, not the new value
		`CHK(d0[15:0], 16'h0001)
		wirq(2);
		`CHK(period, 6)
		for (int s = 0; s < 4; s++) begin
			wr(timer_reload_pkg::ADDR_START, 32'h0);
			wr(timer_reload_pkg::ADDR_TIMER, 32'h1);
			wr(timer_reload_pkg::ADDR_MODE, 32'(s << 1));
			wr(timer_reload_pkg::ADDR_START, 32'h1);
			wirq(2);
			`CHK(period, exp_per[s])
		end
		wr(timer_reload_pkg::ADDR_START, 32'h0);
		wr(timer_reload_pkg::ADDR_TIMER, 32'h9);
		wr(timer_reload_pkg::ADDR_MODE, 32'h18);
		wr(timer_reload_pkg::ADDR_START, 32'h1);
		rd(timer_reload_pkg::ADDR_TIMER, d0, rsp);
		`CHK(d0[15:0], 16'h0009)
		wr(timer_reload_pkg::ADDR_MODE, 32'h08);
		rd(timer_reload_pkg::ADDR_TIMER, d0, rsp);
		`CHK(d0[15:0] != 16'h0009, 1'b1)
		wr(timer_reload_pkg::ADDR_START, 32'h0);
		rd(timer_reload_pkg::ADDR_TIMER, d0, rsp);
		rd(timer_reload_pkg::ADDR_TIMER, d1, rsp);
		`CHK(d1, d0)
		$display("timer test done");
	endtask : t_timer
	// Stopped set-up, then n events, then count and wraps judged
	task automatic evt(input logic [31:0] m, input logic [31:0] ud, input logic [31:0] ld,
		input int src, input int n, input logic [15:0] ec, input int ei);
		int k;
		wr(timer_reload_pkg::ADDR_START, 32'h0);
		wr(timer_reload_pkg::ADDR_MODE, m);
		wr(timer_reload_pkg::ADDR_UPDOWN, ud);
		wr(timer_reload_pkg::ADDR_TIMER, ld);
		wr(timer_reload_pkg::ADDR_START, 32'h1);
		k = n_irq;
		repeat (n) send(src);
		rd(timer_reload_pkg::ADDR_TIMER, d0, rsp);
		`CHK(d0[15:0], ec)
		`CHK(n_irq - k, ei)
	endtask : evt
	task automatic t_event();
		evt(32'h41, 32'h1, 32'hFFFD, 0, 3, 16'hFFFD, 1);
		evt(32'h01, 32'h0, 32'h5, 0, 1, 16'h0004, 0);
		evt(32'hA1, 32'h0, 32'h2, 1, 3, 16'h0002, 1);
		evt(32'h101, 32'h0, 32'h2, 2, 4, 16'h0001, 1);
		evt(32'h481, 32'h1, 32'hFFFF, 1, 2, 16'h0001, 1);
		evt(32'h281, 32'h0, 32'h10, 1, 1, 16'h0011, 0);
		$display("event test done");
	endtask : t_event
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	initial begin
		sys_rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{go, second_group_channel_two, other_first_group_channel} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		ext_dir = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_timer();
		t_event();
		test_done();
	end
endmodule : timer_reload_channel_tb
`default_nettype wire

// ==== timer_reload_monitor.sv ====
// Purpose: Port assertions for the reloadable timer channel
// Assumes: One clock domain, reset active high
// Notes: Bound into every channel instance
`timescale 1ns/1ns
`default_nettype none
module timer_reload_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_output_pin_out,
	input wire logic timer_output_pin_oe,
	input wire logic irq_request,
	input wire logic wrap_pulse
);
	// ****************************************
	// Handshake steps
	// ****************************************
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Address and data taken on one edge
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// ****************************************
	// Checks
	// ****************************************
	a_wrap_mirrors_irq: assert property (wrap_pulse == irq_request)
		else $error("wrap pulse differs from irq");
	a_toggle_on_wrap: assert property ($past(timer_output_pin_oe) && timer_output_pin_oe
		&& $changed(timer_output_pin_out) |-> irq_request) else $error("toggle without wrap");
	// Halves are latched on the take edge, the response rises one edge later
	a_write_answer: assert property (s_wr |=> ##1 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_rd |=> s_axi_rvalid)
		else $error("read data late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
	a_bad_read: assert property (s_rd ##0 s_axi_araddr > 8'h10
		|=> s_axi_rresp == timer_reload_pkg::RESP_SLVERR) else $error("unmapped read okay");
	a_aw_drops: assert property (s_wr |=> !s_axi_awready && !s_axi_wready)
		else $error("ready stayed high");
endmodule : timer_reload_monitor
bind timer_reload_channel timer_reload_monitor i_mon (.*);
`default_nettype wire

// ==== timer_reload_pkg.sv ====
// Purpose: Shared constants and types for the reloadable timer channel.
// Assumes: AXI4-Lite slave with 32-bit data, one word per register.
// Notes: Offsets are byte addresses on the register bus.
package timer_reload_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_TIMER = 8'h00; // Counter read, reload write
	localparam logic [7:0] ADDR_START = 8'h04; // Eight count-start flags
	localparam logic [7:0] ADDR_UPDOWN = 8'h08; // Up/down and two-phase flags
	localparam logic [7:0] ADDR_MODE = 8'h0C; // Channel mode fields
	localparam logic [7:0] ADDR_STATUS = 8'h10; // Live channel state
	localparam logic [7:0] START_RESET = 8'h00;
	localparam logic [7:0] UPDOWN_RESET = 8'h00;
	localparam logic [15:0] TIMER_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_MIN = 16'h0000;
	localparam logic [7:0] TWO_PHASE_MASK = 8'hE0; // Two-phase selects, channels 2..4
	localparam int TWO_PHASE_FIRST_CHAN = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// Prescaler
	// ****************************************
	localparam logic [4:0] DIV8_LAST = 5'h07; // Low three bits all ones
	localparam logic [4:0] DIV32_LAST = 5'h1F;
	localparam logic [4:0] PRESCALE_RESET = 5'h00;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		SRC_DIV_ONE = 2'h0,
		SRC_DIV_EIGHT = 2'h1,
		SRC_DIV_THIRTYTWO = 2'h2,
		SRC_SUBCLK = 2'h3
	} clk_src_t;
	typedef enum logic [1:0] {
		EV_PIN = 2'h0,
		EV_SECOND_GROUP = 2'h1,
		EV_OTHER_CHAN = 2'h2,
		EV_NONE = 2'h3
	} event_src_t;
	// Mode register, bit 0 at the bottom
	typedef struct packed {
		logic free_run; // [10]
		logic dir_from_pin; // [9]
		event_src_t event_src; // [8:7]
		logic rising_edge; // [6]
		logic pulse_out; // [5]
		logic gate_high; // [4]
		logic gate_en; // [3]
		clk_src_t clk_src; // [2:1]
		logic event_mode; // [0]
	} mode_t;
	localparam mode_t MODE_RESET = '0;
endpackage : timer_reload_pkg
